// ### hdl/mpsm_pkg.sv
/*
 * Package for the module power state manager: power states, sync depth, timing counts.
 * Assumes a single 10 MHz standby-domain clock.
 */
package mpsm_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS      = 100;
	localparam int unsigned IMMINENT_TIME_NS   = 1000;
	localparam int unsigned IMMINENT_CYCLES    = (IMMINENT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RESET_PULSE_NS     = 1000;
	localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W              = 8;

	// ------------------------------------------------------------
	// Input synchroniser
	// ------------------------------------------------------------
	localparam int unsigned SYNC_STAGES = 3;
	localparam int unsigned N_INPUTS    = 6;
	localparam logic [N_INPUTS-1:0] SYNC_RESET_VAL = 6'h3f;
	localparam int unsigned IDX_POWER_BUTTON_N  = 0;
	localparam int unsigned IDX_RSTBTN  = 1;
	localparam int unsigned IDX_PGOOD   = 2;
	localparam int unsigned IDX_PCIE_WAKEUP_N   = 3;
	localparam int unsigned IDX_GENERAL_WAKEUP_N   = 4;
	localparam int unsigned IDX_BATTERY_LOW_N  = 5;

	// ------------------------------------------------------------
	// Power states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MPSM_OFF,
		MPSM_RUN,
		MPSM_PREP,
		MPSM_RAM,
		MPSM_DISK
	} mpsm_state_t;

	typedef enum logic [1:0] {
		MPSM_SLP_RAM,
		MPSM_SLP_DISK,
		MPSM_SLP_OFF
	} mpsm_target_t;

endpackage : mpsm_pkg

// ### hdl/mpsm_sync.sv
/*
 * Three-flop synchroniser bank with agreement filter for carrier-side inputs.
 * Assumes inputs are asynchronous to ref_clk; reset is synchronous, active low.
 */
`timescale 1ns/1ns
module mpsm_sync
(
	input  wire logic                          ref_clk,
	input  wire logic                          resetn,
	input  wire logic [mpsm_pkg::N_INPUTS-1:0] async_in,
	output logic      [mpsm_pkg::N_INPUTS-1:0] clean_q
);
	import mpsm_pkg::*;

	// ------------------------------------------------------------
	// Per-input flop chain
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_INPUTS; g++) begin : g_bit
			logic [SYNC_STAGES-1:0] chain_q;
			// Stage one feeds only stage two
			always_ff @(posedge ref_clk) begin
				if (!resetn) begin
					chain_q <= {SYNC_STAGES{SYNC_RESET_VAL[g]}};
				end else begin
					chain_q <= {chain_q[SYNC_STAGES-2:0], async_in[g]};
				end
			end
			// Accept a change once stages two and three agree
			always_ff @(posedge ref_clk) begin
				if (!resetn) begin
					clean_q[g] <= SYNC_RESET_VAL[g];
				end else if (chain_q[1] == chain_q[2]) begin
					clean_q[g] <= chain_q[2];
				end
			end
		end
	endgenerate

endmodule : mpsm_sync

// ### hdl/mpsm_top.sv
/*
 * Module power state manager: buttons, power-good, wake and battery-low in;
 * carrier reset and suspend-state indications out.
 * Assumes one 10 MHz standby clock, synchronous active-low reset, and that the
 * platform supplies supply-low, watchdog and software requests as same-clock levels/pulses.
 */
`timescale 1ns/1ns
module mpsm_top
(
	input  wire logic     ref_clk,
	input  wire logic     resetn,
	input  wire logic     power_button_n,
	input  wire logic     reset_button_n,
	input  wire logic     power_good,
	input  wire logic     main_supply_low,
	input  wire logic     pcie_wakeup_n,
	input  wire logic     general_wakeup_n,
	input  wire logic     battery_low_n,
	input  wire logic     reset_edge_mode,
	input  wire logic     watchdog_timeout,
	input  wire logic     sw_reset_req,
	input  wire logic     sleep_req,
	input  wire mpsm_pkg::mpsm_target_t sleep_target,
	output logic          carrier_reset_out_n,
	output logic          suspend_imminent_n,
	output logic          sleep_ram_n,
	output logic          sleep_disk_n,
	output logic          soft_off_n,
	output logic          battery_low_q,
	output logic          power_event_q,
	output logic          system_on_q
);
	import mpsm_pkg::*;

	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------
	logic [N_INPUTS-1:0] clean;
	logic [N_INPUTS-1:0] prev_q;
	wire  [N_INPUTS-1:0] pins;

	// Pins gathered by index, so bit order follows the package
	assign pins[IDX_POWER_BUTTON_N] = power_button_n;
	assign pins[IDX_RSTBTN] = reset_button_n;
	assign pins[IDX_PGOOD]  = power_good;
	assign pins[IDX_PCIE_WAKEUP_N]  = pcie_wakeup_n;
	assign pins[IDX_GENERAL_WAKEUP_N]  = general_wakeup_n;
	assign pins[IDX_BATTERY_LOW_N] = battery_low_n;

	// Carrier inputs pass the synchroniser bank
	mpsm_sync i_mpsm_sync (
		.ref_clk  (ref_clk),
		.resetn   (resetn),
		.async_in (pins),
		.clean_q  (clean)
	);

	// Previous clean values for edge detection
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			prev_q <= SYNC_RESET_VAL;
		end else begin
			prev_q <= clean;
		end
	end

	logic power_button_n_fall;
	logic rstbtn_fall;
	logic pgood;
	logic wake_any;
	logic reset_req;

	// Events and decoded levels
	assign power_button_n_fall = prev_q[IDX_POWER_BUTTON_N] & ~clean[IDX_POWER_BUTTON_N];
	assign rstbtn_fall = prev_q[IDX_RSTBTN] & ~clean[IDX_RSTBTN];
	assign pgood       = clean[IDX_PGOOD];
	assign wake_any    = ~clean[IDX_PCIE_WAKEUP_N] | ~clean[IDX_GENERAL_WAKEUP_N];
	// Level or edge reset request by mode
	assign reset_req   = reset_edge_mode ? rstbtn_fall : ~clean[IDX_RSTBTN];

	// ------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------
	mpsm_state_t      state_q;
	mpsm_target_t     target_q;
	logic [CNT_W-1:0] prep_cnt_q;

	// State transitions
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state_q    <= MPSM_OFF;
			target_q   <= MPSM_SLP_OFF;
			prep_cnt_q <= '0;
		end else if (!pgood) begin
			state_q    <= MPSM_OFF;
			target_q   <= MPSM_SLP_OFF;
			prep_cnt_q <= '0;
		end else begin
			unique case (state_q)
				MPSM_OFF: begin
					if (power_button_n_fall) begin
						state_q <= MPSM_RUN;
					end
				end
				MPSM_RUN: begin
					if (power_button_n_fall) begin
						target_q   <= MPSM_SLP_OFF;
						prep_cnt_q <= CNT_W'(IMMINENT_CYCLES);
						state_q    <= MPSM_PREP;
					end else if (sleep_req) begin
						target_q   <= sleep_target;
						prep_cnt_q <= CNT_W'(IMMINENT_CYCLES);
						state_q    <= MPSM_PREP;
					end
				end
				MPSM_PREP: begin
					// Hold imminent notice before entering suspend
					if (prep_cnt_q > CNT_W'(1)) begin
						prep_cnt_q <= prep_cnt_q - CNT_W'(1);
					end else begin
						prep_cnt_q <= '0;
						unique case (target_q)
							MPSM_SLP_RAM:  state_q <= MPSM_RAM;
							MPSM_SLP_DISK: state_q <= MPSM_DISK;
							default:       state_q <= MPSM_OFF;
						endcase
					end
				end
				MPSM_RAM, MPSM_DISK: begin
					if (power_button_n_fall || wake_any) begin
						state_q <= MPSM_RUN;
					end
				end
				default: state_q <= MPSM_OFF;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State decode
	// ------------------------------------------------------------
	logic in_off;
	logic in_run;
	logic in_prep;
	logic in_ram;
	logic in_disk;

	// One flag per power state, shared by reset and indications
	assign in_off  = (state_q == MPSM_OFF);
	assign in_run  = (state_q == MPSM_RUN);
	assign in_prep = (state_q == MPSM_PREP);
	assign in_ram  = (state_q == MPSM_RAM);
	assign in_disk = (state_q == MPSM_DISK);

	// ------------------------------------------------------------
	// Carrier reset
	// ------------------------------------------------------------
	logic [CNT_W-1:0] rst_cnt_q;
	logic             rst_cause;

	// Any cause asserts reset; pulse causes stretched to a minimum width
	assign rst_cause = reset_req | ~pgood | main_supply_low
	                 | watchdog_timeout | sw_reset_req;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rst_cnt_q <= CNT_W'(RESET_PULSE_CYCLES);
		end else if (rst_cause) begin
			rst_cnt_q <= CNT_W'(RESET_PULSE_CYCLES);
		end else if (rst_cnt_q != '0) begin
			rst_cnt_q <= rst_cnt_q - CNT_W'(1);
		end
	end

	// Reset output registered; also held while not running
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			carrier_reset_out_n <= 1'b0;
		end else begin
			carrier_reset_out_n <= ~rst_cause && (rst_cnt_q == '0) && in_run;
		end
	end

	// ------------------------------------------------------------
	// State indications and status
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			suspend_imminent_n <= 1'b1;
			sleep_ram_n        <= 1'b1;
			sleep_disk_n       <= 1'b1;
			soft_off_n         <= 1'b0;
			battery_low_q      <= 1'b0;
			power_event_q      <= 1'b0;
			system_on_q        <= 1'b0;
		end else begin
			suspend_imminent_n <= ~in_prep;
			sleep_ram_n        <= ~in_ram;
			sleep_disk_n       <= ~in_disk;
			soft_off_n         <= ~in_off;
			battery_low_q      <= ~clean[IDX_BATTERY_LOW_N];
			power_event_q      <= power_button_n_fall;
			system_on_q        <= in_run;
		end
	end

endmodule : mpsm_top

// ### verif/mpsm_top_sva.sv
/* Port checker for the module power state manager.
 * Assumes binding into mpsm_top with its 10 MHz clock and sync low reset. */
`timescale 1ns/1ns
module mpsm_top_chk (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic reset_button_n,
	input wire logic power_good,
	input wire logic main_supply_low,
	input wire logic battery_low_n,
	input wire logic reset_edge_mode,
	input wire logic watchdog_timeout,
	input wire logic sw_reset_req,
	input wire logic carrier_reset_out_n,
	input wire logic suspend_imminent_n,
	input wire logic sleep_ram_n,
	input wire logic sleep_disk_n,
	input wire logic soft_off_n,
	input wire logic battery_low_q,
	input wire logic power_event_q,
	input wire logic system_on_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Event, reset causes, state indications
	property p_evt; power_event_q |=> !power_event_q; endproperty
	a_evt: assert property (p_evt) else $error("power event wider than one cycle");
	property p_sup; main_supply_low |=> !carrier_reset_out_n; endproperty
	a_sup: assert property (p_sup) else $error("supply low without carrier reset");
	property p_wdg; watchdog_timeout |=> !carrier_reset_out_n; endproperty
	a_wdg: assert property (p_wdg) else $error("watchdog without carrier reset");
	property p_swr; sw_reset_req |=> !carrier_reset_out_n; endproperty
	a_swr: assert property (p_swr) else $error("software reset without carrier reset");
	property p_btn; (!reset_button_n && !reset_edge_mode)[*6] |=> !carrier_reset_out_n; endproperty
	a_btn: assert property (p_btn) else $error("held reset button without carrier reset");
	property p_pg; !power_good[*6] |=> !system_on_q && !carrier_reset_out_n; endproperty
	a_pg: assert property (p_pg) else $error("running while power not good");
	property p_imm; $fell(sleep_ram_n) || $fell(sleep_disk_n) |-> !$past(suspend_imminent_n); endproperty
	a_imm: assert property (p_imm) else $error("suspend without prior notice");
	property p_ram; !sleep_ram_n |-> !system_on_q && sleep_disk_n && soft_off_n; endproperty
	a_ram: assert property (p_ram) else $error("ram indication in wrong state");
	property p_dsk; !sleep_disk_n |-> !system_on_q && soft_off_n; endproperty
	a_dsk: assert property (p_dsk) else $error("disk indication in wrong state");
	property p_off; !soft_off_n |-> !system_on_q && !carrier_reset_out_n; endproperty
	a_off: assert property (p_off) else $error("soft-off indication while running");
	property p_bat; !battery_low_n[*6] |=> battery_low_q; endproperty
	a_bat: assert property (p_bat) else $error("battery low not reported");
endmodule : mpsm_top_chk
bind mpsm_top mpsm_top_chk i_chk (.ref_clk, .resetn, .reset_button_n, .power_good, .main_supply_low,
	.battery_low_n, .reset_edge_mode, .watchdog_timeout, .sw_reset_req, .carrier_reset_out_n,
	.suspend_imminent_n, .sleep_ram_n, .sleep_disk_n, .soft_off_n, .battery_low_q, .power_event_q,
	.system_on_q);

// ### verif/mpsm_carrier.sv
/* Carrier board model: buttons, wake lines, battery and supply good.
 * Assumes the bench calls tap at falling clock edges. */
`timescale 1ns/1ns
module mpsm_carrier (
	input  wire logic ref_clk,
	input  wire logic sleep_ram_n,
	output logic      power_button_n,
	output logic      reset_button_n,
	output logic      power_good,
	output logic      pcie_wakeup_n,
	output logic      general_wakeup_n,
	output logic      battery_low_n,
	output logic      atx_main_on
);
	logic [4:0] line_q = 5'h1f; // Pulled-up lines idle high
	logic       pgood_q = 1'b0; // Held low until carrier logic is ready
	assign {battery_low_n, general_wakeup_n, pcie_wakeup_n, reset_button_n, power_button_n} = line_q;
	assign power_good = pgood_q;
	assign atx_main_on = ~sleep_ram_n; // Inverted copy drives supply enable
	// Press one line low for n cycles
	task tap(input int idx, input int n);
		@(negedge ref_clk);
		line_q[idx] = 1'b0;
		repeat (n) @(negedge ref_clk);
		line_q[idx] = 1'b1;
	endtask : tap
endmodule : mpsm_carrier

// ### verif/mpsm_bench.sv
/* Self-checking bench for mpsm_top with carrier model.
 * Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
module mpsm_bench;
	import mpsm_pkg::*;
	logic ref_clk = 0, resetn = 0, main_supply_low = 0, reset_edge_mode = 0;
	logic watchdog_timeout = 0, sw_reset_req = 0, sleep_req = 0;
	mpsm_target_t sleep_target = MPSM_SLP_RAM;
	wire logic pb_n, rb_n, pg, w0_n, w1_n, bl_n, crst_n, imm_n, ram_n, dsk_n, off_n, bat_q, pev_q, on_q;
	int n_mismatch = 0, samples_checked = 0, cyc = 0, stab = 0, seed = 56974;
	int imm_len = 0, pev_n = 0;
	logic [4:0] expq[$], prev_v, last_v = 5'b00110, b;
	logic [4:0] sv[3] = '{5'b00011, 5'b00101, 5'b00110};
	wire logic [4:0] v = {crst_n, on_q, ram_n, dsk_n, off_n};
	always #50 ref_clk = ~ref_clk;
	mpsm_carrier i_mpsm_carrier (.ref_clk(ref_clk), .sleep_ram_n(ram_n), .power_button_n(pb_n),
		.reset_button_n(rb_n), .power_good(pg), .pcie_wakeup_n(w0_n), .general_wakeup_n(w1_n),
		.battery_low_n(bl_n), .atx_main_on());
	mpsm_top i_mpsm_top (.ref_clk(ref_clk), .resetn(resetn), .power_button_n(pb_n), .reset_button_n(rb_n),
		.power_good(pg), .main_supply_low(main_supply_low), .pcie_wakeup_n(w0_n), .general_wakeup_n(w1_n),
		.battery_low_n(bl_n), .reset_edge_mode(reset_edge_mode), .watchdog_timeout(watchdog_timeout),
		.sw_reset_req(sw_reset_req), .sleep_req(sleep_req), .sleep_target(sleep_target),
		.carrier_reset_out_n(crst_n), .suspend_imminent_n(imm_n), .sleep_ram_n(ram_n), .sleep_disk_n(dsk_n),
		.soft_off_n(off_n), .battery_low_q(bat_q), .power_event_q(pev_q), .system_on_q(on_q));
	task chk(string nm, logic [4:0] e, logic [4:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk
	task conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	task two(logic [4:0] a, logic [4:0] c);
		expq.push_back(a);
		expq.push_back(c);
	endtask : two
	// Wait until every noted state was seen and settled
	task drain(string nm);
		repeat (300) if (expq.size() != 0 || stab < 3) @(negedge ref_clk);
		chk({nm, " pending"}, 5'h0, 5'(expq.size()));
		repeat (3 + ($random(seed) & 7)) @(negedge ref_clk);
		$display("test %s done", nm);
	endtask : drain
	// Stable change of the indication vector takes the oldest note
	always @(negedge ref_clk) begin
		cyc++;
		stab = (v === prev_v) ? stab + 1 : 0;
		prev_v = v;
		if (imm_n === 1'b0) imm_len++;
		if (pev_q === 1'b1) pev_n++;
		if (stab == 3 && v !== last_v) begin
			last_v = v;
			chk("state", (expq.size() > 0) ? expq.pop_front() : ~v, v);
		end
		if (cyc == 8000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		repeat (3) @(negedge ref_clk);
		resetn = 1;
		repeat (10) @(negedge ref_clk);
		i_mpsm_carrier.tap(0, 6);
		drain("hold_off");
		i_mpsm_carrier.pgood_q = 1;
		two(5'b01111, 5'h1f);
		pev_n = 0;
		i_mpsm_carrier.tap(0, 6);
		drain("power_on");
		chk("power_event", 5'h01, 5'(pev_n));
		for (int k = 0; k < 3; k++) begin
			two(5'b01111, 5'h1f);
			{main_supply_low, watchdog_timeout, sw_reset_req} = 3'h4 >> k;
			@(negedge ref_clk);
			{main_supply_low, watchdog_timeout, sw_reset_req} = 3'h0;
			drain("reset_cause");
		end
		two(5'b01111, 5'h1f);
		i_mpsm_carrier.tap(1, 20);
		drain("button_level");
		reset_edge_mode = 1;
		two(5'b01111, 5'h1f);
		fork
			i_mpsm_carrier.tap(1, 40);
			begin
				repeat (35) @(negedge ref_clk);
				chk("edge_mode", 5'h1f, v);
			end
		join
		drain("button_edge");
		reset_edge_mode = 0;
		for (int i = 0; i < 3; i++) begin
			two(5'b00111, sv[i]);
			imm_len = 0;
			sleep_req = 1;
			sleep_target = mpsm_target_t'(i);
			@(negedge ref_clk);
			sleep_req = 0;
			drain("sleep");
			chk("imminent", 5'(IMMINENT_CYCLES), 5'(imm_len));
			expq.push_back(5'h1f);
			i_mpsm_carrier.tap((i == 2) ? 0 : i + 2, 8);
			drain("wake");
		end
		two(5'b00111, 5'b00110);
		i_mpsm_carrier.tap(0, 6);
		drain("power_down");
		expq.push_back(5'h1f);
		i_mpsm_carrier.tap(0, 6);
		drain("power_on_again");
		expq.push_back(5'b00110);
		i_mpsm_carrier.pgood_q = 0;
		drain("pgood_loss");
		for (int j = 0; j < 4; j++) begin
			b = 5'($random(seed) & 1);
			i_mpsm_carrier.line_q[4] = b[0];
			repeat (8) @(negedge ref_clk);
			chk("battery", {4'h0, ~b[0]}, {4'h0, bat_q});
		end
		$display("test battery done");
		conclude();
	end
endmodule : mpsm_bench
